// ---- rtl/intc_pkg.sv ----
// Constants, register map and types of the interrupt and reset controller
package intc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [1:0] EXT_CTRL_OFS = 2'h0;  // Ext interrupt control
  localparam logic [1:0] PRIO_SEL_OFS = 2'h1;  // Priority select
  localparam logic [1:0] STATUS_OFS   = 2'h2;  // Reset cause and pin state

  // Control register bit positions
  localparam int EDGE_SEL_BIT = 7;  // Edge select
  localparam int CONNECT_BIT  = 6;  // Pin connect
  localparam int DELAY_BIT    = 5;  // Stop exit delay

  // Reset values
  localparam logic [7:0] PRIO_RESET    = 8'hf2;  // Pin is top maskable
  localparam logic       EDGE_RESET    = 1'b0;   // Level sensitive
  localparam logic       CONNECT_RESET = 1'b1;   // Pin connected
  localparam logic       DELAY_RESET   = 1'b1;   // Delay on stop exit

  // ---------------------------------------------------------------
  // Vectors, highest priority first
  // ---------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'hfffe;  // Power-on and pin
  localparam logic [15:0] VEC_CMON  = 16'hfffc;  // Clock monitor
  localparam logic [15:0] VEC_WDOG  = 16'hfffa;  // Watchdog
  localparam logic [15:0] VEC_TRAP  = 16'hfff8;  // Unimplemented opcode
  localparam logic [15:0] VEC_SWI   = 16'hfff6;  // Software trap
  localparam logic [15:0] VEC_NMI   = 16'hfff4;  // Nonmaskable pin
  localparam logic [7:0]  VEC_HIGH  = 8'hff;     // Upper vector byte

  // Maskable sources, index 0 is the external pin, last is CAN transmit
  localparam int NUM_MASKABLE = 21;
  localparam logic [NUM_MASKABLE-1:0][7:0] MASK_VEC = {
    8'hc4, 8'hc6, 8'hc8, 8'hd0, 8'hd2, 8'hd4, 8'hd6, 8'hd8, 8'hda,
    8'hdc, 8'hde, 8'he0, 8'he2, 8'he4, 8'he6, 8'he8, 8'hea, 8'hec,
    8'hee, 8'hf0, 8'hf2};

  // ---------------------------------------------------------------
  // Timing in bus clock cycles
  // ---------------------------------------------------------------
  localparam int RST_DRIVE_CYCLES  = 16;    // Reset pin driven low
  localparam int RST_SAMPLE_CYCLES = 8;     // Release to sample
  localparam int STOP_DELAY_CYCLES = 4096;  // Oscillator settle

  // Reset cause encoding
  localparam logic [1:0] CAUSE_POR  = 2'h0;
  localparam logic [1:0] CAUSE_EXT  = 2'h1;
  localparam logic [1:0] CAUSE_WDOG = 2'h2;
  localparam logic [1:0] CAUSE_CMON = 2'h3;

  // Vector fetch handed to the CPU
  typedef struct packed {
    logic        valid;  // One-cycle strobe
    logic        reset;  // Fetch is a reset vector
    logic [15:0] addr;   // Vector address
  } vector_fetch_s;

endpackage : intc_pkg

// ---- rtl/interrupt_priority_reset_control.sv ----
// Interrupt priority, pin latching and reset classification logic
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module interrupt_priority_reset_control
  import intc_pkg::*;
#(
  parameter int STOP_DELAY = STOP_DELAY_CYCLES  // Stop exit settle count
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic [1:0]              addr,
  input  wire logic [7:0]              wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic [7:0]                   rd_data,
  input  wire logic                    special_mode,
  input  wire logic                    ccr_i_mask,
  input  wire logic                    ccr_x_mask,
  input  wire logic                    ext_request_pin_n,
  input  wire logic                    nonmaskable_request_pin_n,
  input  wire logic [NUM_MASKABLE-2:0] periph_req,
  input  wire logic [NUM_MASKABLE-2:0] periph_enable,
  input  wire logic                    unimpl_trap_req,
  input  wire logic                    software_trap_req,
  input  wire logic                    service_start,
  output logic                         cpu_irq_req,
  output logic                         cpu_nmi_req,
  output vector_fetch_s                vector_fetch,
  input  wire logic                    watchdog_fail,
  input  wire logic                    clock_monitor_fail,
  input  wire logic                    reset_pin_in,
  output logic                         reset_pin_out,
  output logic                         reset_pin_oe,
  output logic                         core_reset,
  input  wire logic                    stop_exit_req,
  output logic                         stop_exit_done
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  localparam int CW = $clog2(STOP_DELAY + 1);  // Stop counter width

  // Index of the promoted source; unknown bytes fall to the pin
  function automatic logic [4:0] promoted_index(input logic [7:0] v);
    logic [4:0] idx;
    idx = 5'h0;
    for (int i = 1; i < NUM_MASKABLE; i++) begin
      if (v == MASK_VEC[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : promoted_index

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic ext_s1_reg, ext_s2_reg, ext_s3_reg;  // External request pin
  logic nmi_s1_reg, nmi_s2_reg;              // Nonmaskable pin
  logic rst_s1_reg, rst_s2_reg;              // Reset pin readback

  // Two flops per pin, third stage only for edge detection
  always_ff @(posedge ref_clk) begin
    ext_s1_reg <= ext_request_pin_n;
    ext_s2_reg <= ext_s1_reg;
    ext_s3_reg <= ext_s2_reg;
    nmi_s1_reg <= nonmaskable_request_pin_n;
    nmi_s2_reg <= nmi_s1_reg;
    rst_s1_reg <= reset_pin_in;
    rst_s2_reg <= rst_s1_reg;
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  logic       edge_sel_reg;      // Edge select
  logic       connect_reg;       // Pin connect
  logic       delay_reg;         // Stop exit delay
  logic       edge_written_reg;  // A write to edge select was seen
  logic       delay_written_reg; // A write to delay was seen
  logic [7:0] prio_reg;          // Priority select
  logic       ctrl_wr;           // Control register write
  logic       edge_ok;           // Edge select write allowed

  assign ctrl_wr = wr_en && (addr == EXT_CTRL_OFS);
  // Normal: first write only; special: all but the first
  assign edge_ok = special_mode ? edge_written_reg
                                : !edge_written_reg;

  // Edge select with its write history
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      edge_sel_reg     <= EDGE_RESET;
      edge_written_reg <= 1'b0;
    end else if (ctrl_wr) begin
      edge_written_reg <= 1'b1;
      if (edge_ok) begin
        edge_sel_reg <= wr_data[EDGE_SEL_BIT];
      end
    end
  end

  // Pin connect, writable at all times
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      connect_reg <= CONNECT_RESET;
    end else if (ctrl_wr) begin
      connect_reg <= wr_data[CONNECT_BIT];
    end
  end

  // Stop delay, write-once outside special modes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      delay_reg         <= DELAY_RESET;
      delay_written_reg <= 1'b0;
    end else if (ctrl_wr) begin
      delay_written_reg <= 1'b1;
      if (special_mode || !delay_written_reg) begin
        delay_reg <= wr_data[DELAY_BIT];
      end
    end
  end

  // Priority select, guarded by the global mask
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prio_reg <= PRIO_RESET;
    end else if (wr_en && addr == PRIO_SEL_OFS && ccr_i_mask) begin
      prio_reg <= wr_data;
    end
  end

  // ---------------------------------------------------------------
  // Request qualification
  // ---------------------------------------------------------------
  logic                    edge_latch_reg;  // Captured falling edge
  logic                    irq_pin_req;     // External pin request
  logic [NUM_MASKABLE-1:0] mask_act;        // Enabled maskables
  logic                    nmi_req;         // Nonmaskable pin request
  logic                    fall_seen;       // Falling edge on pin
  logic [4:0]              prom_idx;        // Promoted source

  assign fall_seen = ext_s3_reg && !ext_s2_reg && connect_reg;
  // Level mode reads the pin, edge mode the latch
  assign irq_pin_req = edge_sel_reg ? edge_latch_reg
                                    : (connect_reg && !ext_s2_reg);
  assign mask_act = ccr_i_mask ? '0
                  : {periph_req & periph_enable, irq_pin_req};
  assign nmi_req  = !nmi_s2_reg && !ccr_x_mask;
  assign prom_idx = promoted_index(prio_reg);
  assign cpu_irq_req = |mask_act;
  assign cpu_nmi_req = nmi_req;

  // ---------------------------------------------------------------
  // Vector selection at service start
  // ---------------------------------------------------------------
  logic [15:0] svc_vec;   // Chosen vector
  logic        svc_irq;   // Chosen source is the external pin

  // Fixed order, promoted maskable ahead of the rest
  always_comb begin
    svc_vec = VEC_TRAP;
    svc_irq = 1'b0;
    if (unimpl_trap_req) begin
      svc_vec = VEC_TRAP;
    end else if (software_trap_req) begin
      svc_vec = VEC_SWI;
    end else if (nmi_req) begin
      svc_vec = VEC_NMI;
    end else if (mask_act[prom_idx]) begin
      svc_vec = {VEC_HIGH, MASK_VEC[prom_idx]};
      svc_irq = (prom_idx == 5'h0);
    end else begin
      // Lowest index wins among the rest
      for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
        if (mask_act[i]) begin
          svc_vec = {VEC_HIGH, MASK_VEC[i]};
          svc_irq = (i == 0);
        end
      end
    end
  end

  // Edge latch; a new edge wins over the service clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      edge_latch_reg <= 1'b0;
    end else if (edge_sel_reg && fall_seen) begin
      edge_latch_reg <= 1'b1;
    end else if (service_start && svc_irq) begin
      edge_latch_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Reset classification
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RS_DRIVE, RS_WAIT, RS_HOLD, RS_RUN} rst_state_e;
  rst_state_e rst_state_reg;  // Sequence state
  logic [4:0] rst_cnt_reg;    // Sequence counter
  logic [1:0] cause_reg;      // Recorded reset cause
  logic       rst_vec_fire;   // Reset vector strobe
  logic [15:0] rst_vec;       // Reset vector for the cause

  // Drive low, release, wait, then read the pin
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rst_state_reg <= RS_DRIVE;
      rst_cnt_reg   <= 5'h0;
      cause_reg     <= CAUSE_POR;
    end else begin
      unique case (rst_state_reg)
        RS_DRIVE: begin
          rst_cnt_reg <= rst_cnt_reg + 5'h1;
          if (rst_cnt_reg == 5'(RST_DRIVE_CYCLES - 1)) begin
            rst_state_reg <= RS_WAIT;
            rst_cnt_reg   <= 5'h0;
          end
        end
        RS_WAIT: begin
          rst_cnt_reg <= rst_cnt_reg + 5'h1;
          if (rst_cnt_reg == 5'(RST_SAMPLE_CYCLES - 1)) begin
            if (!rst_s2_reg) begin
              cause_reg     <= CAUSE_EXT;
              rst_state_reg <= RS_HOLD;
            end else begin
              rst_state_reg <= RS_RUN;
            end
          end
        end
        RS_HOLD: begin
          if (rst_s2_reg) begin
            rst_state_reg <= RS_RUN;
          end
        end
        RS_RUN: begin
          if (clock_monitor_fail || watchdog_fail || !rst_s2_reg) begin
            rst_state_reg <= RS_DRIVE;
            rst_cnt_reg   <= 5'h0;
            cause_reg     <= clock_monitor_fail ? CAUSE_CMON
                           : watchdog_fail      ? CAUSE_WDOG
                                                : CAUSE_POR;
          end
        end
      endcase
    end
  end

  assign rst_vec_fire = (rst_state_reg == RS_HOLD && rst_s2_reg)
                     || (rst_state_reg == RS_WAIT && rst_s2_reg
                         && rst_cnt_reg == 5'(RST_SAMPLE_CYCLES - 1));
  // External and power-on share the main vector
  assign rst_vec = (rst_state_reg == RS_HOLD) ? VEC_RESET
                 : (cause_reg == CAUSE_CMON)  ? VEC_CMON
                 : (cause_reg == CAUSE_WDOG)  ? VEC_WDOG
                                              : VEC_RESET;

  // Open-drain drive during the low phase only
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe  = (rst_state_reg == RS_DRIVE);
  // Entry on reset, watchdog or clock monitor is immediate, release waits for the sequence
  assign core_reset = reset || watchdog_fail || clock_monitor_fail
                   || (rst_state_reg != RS_RUN);

  // ---------------------------------------------------------------
  // Vector fetch output
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      vector_fetch <= '0;
    end else if (rst_vec_fire) begin
      vector_fetch <= '{valid: 1'b1, reset: 1'b1, addr: rst_vec};
    end else if (service_start && rst_state_reg == RS_RUN) begin
      vector_fetch <= '{valid: 1'b1, reset: 1'b0, addr: svc_vec};
    end else begin
      vector_fetch.valid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Stop mode exit
  // ---------------------------------------------------------------
  logic [CW-1:0] stop_cnt_reg;  // Remaining settle cycles
  logic          stop_busy_reg; // Settle in progress

  // Count the settle time, or finish next cycle without it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stop_cnt_reg   <= '0;
      stop_busy_reg  <= 1'b0;
      stop_exit_done <= 1'b0;
    end else begin
      stop_exit_done <= 1'b0;
      if (stop_busy_reg) begin
        stop_cnt_reg <= stop_cnt_reg - 1'b1;
        if (stop_cnt_reg == CW'(1)) begin
          stop_busy_reg  <= 1'b0;
          stop_exit_done <= 1'b1;
        end
      end else if (stop_exit_req) begin
        if (delay_reg) begin
          stop_busy_reg <= 1'b1;
          stop_cnt_reg  <= CW'(STOP_DELAY);
        end else begin
          stop_exit_done <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data <= '0;
    end else if (rd_en) begin
      unique case (addr)
        EXT_CTRL_OFS: rd_data <= {edge_sel_reg, connect_reg, delay_reg, 5'h0};
        PRIO_SEL_OFS: rd_data <= prio_reg;
        STATUS_OFS:   rd_data <= {cause_reg, edge_latch_reg, rst_s2_reg,
                                  4'h0};
        default:      rd_data <= '0;
      endcase
    end else begin
      rd_data <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  prio_write_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
    wr_en && addr == PRIO_SEL_OFS && !ccr_i_mask |=> $stable(prio_reg))
    else $error("priority written while unmasked");

  reset_values_a: assert property (@(posedge ref_clk)
    reset |=> prio_reg == PRIO_RESET && !edge_sel_reg && delay_reg)
    else $error("wrong reset values");

  edge_once_a: assert property (@(posedge ref_clk) disable iff (reset)
    ctrl_wr && !special_mode && edge_written_reg |=> $stable(edge_sel_reg))
    else $error("edge select rewritten in normal mode");

  pin_drive_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(reset_pin_oe) |-> reset_pin_oe[*8] ##1 reset_pin_oe[*8]
    ##1 !reset_pin_oe)
    else $error("reset pin drive length wrong");

  sample_wait_a: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(reset_pin_oe) |-> (rst_state_reg == RS_WAIT)[*8])
    else $error("reset pin sampled early");

  empty_trap_a: assert property (@(posedge ref_clk) disable iff (reset)
    service_start && rst_state_reg == RS_RUN && !rst_vec_fire && !nmi_req
    && mask_act == '0 && !software_trap_req |=> vector_fetch.addr == VEC_TRAP)
    else $error("empty service did not take trap");

  irq_masked_a: assert property (@(posedge ref_clk) disable iff (reset)
    cpu_irq_req |-> !ccr_i_mask)
    else $error("maskable request while masked");

  nmi_masked_a: assert property (@(posedge ref_clk) disable iff (reset)
    cpu_nmi_req |-> !ccr_x_mask && !nmi_s2_reg)
    else $error("nonmaskable request while masked");

  stop_delay_a: assert property (@(posedge ref_clk) disable iff (reset)
    stop_exit_req && !stop_busy_reg && delay_reg |=> !stop_exit_done[*8])
    else $error("stop exit ended before settle time");

endmodule : interrupt_priority_reset_control

`default_nettype wire

// ---- testbench/ext_side_model.sv ----
// Pin side model: reset pin with pull-up and the two request pins
`timescale 1ns/1ps
`default_nettype none

module ext_side_model (
  input  wire logic ref_clk,
  input  wire logic reset_pin_out,
  input  wire logic reset_pin_oe,
  output logic      reset_pin_in,
  output logic      ext_request_pin_n,
  output logic      nonmaskable_request_pin_n
);
  logic ext_low;  // External source pulls pin

  // Wired pin: device drive wins, else pull-up or outside source
  assign reset_pin_in = reset_pin_oe ? reset_pin_out : !ext_low;

  // Idle pins at time zero
  initial begin
    ext_low = 1'b0;
    ext_request_pin_n = 1'b1;
    nonmaskable_request_pin_n = 1'b1;
  end

  // Outside reset: never shorter than 32 cycles
  task automatic pull_reset(input int n);
    @(posedge ref_clk);
    ext_low <= 1'b1;
    repeat ((n < 32) ? 32 : n) @(posedge ref_clk);
    ext_low <= 1'b0;
  endtask : pull_reset

  // Pin levels, held until the next call changes them
  task automatic set_pins(input logic irq_n, input logic nmi_n);
    @(posedge ref_clk);
    ext_request_pin_n <= irq_n;
    nonmaskable_request_pin_n <= nmi_n;
  endtask : set_pins
endmodule : ext_side_model
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the interrupt and reset controller
`timescale 1ns/1ps
`default_nettype none

module tb
  import intc_pkg::*;
;
  localparam int SD = 16;  // Short stop exit count
  logic ref_clk, reset, wr_en, rd_en, special_mode, ccr_i_mask, ccr_x_mask;
  logic [1:0]    addr;
  logic [7:0]    wr_data, rd_data, d;
  logic [19:0]   periph_req, periph_enable;
  logic          unimpl_trap_req, software_trap_req, service_start;
  logic          cpu_irq_req, cpu_nmi_req, watchdog_fail, clock_monitor_fail;
  logic          reset_pin_in, reset_pin_out, reset_pin_oe, core_reset;
  logic          stop_exit_req, stop_exit_done;
  logic          ext_request_pin_n, nonmaskable_request_pin_n;
  vector_fetch_s vector_fetch;
  int            n_mismatch = 0, tests_run = 0, cycles = 0;

  interrupt_priority_reset_control #(.STOP_DELAY(SD)) dut (
    .ref_clk, .reset, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .special_mode, .ccr_i_mask, .ccr_x_mask, .ext_request_pin_n,
    .nonmaskable_request_pin_n, .periph_req, .periph_enable,
    .unimpl_trap_req, .software_trap_req, .service_start, .cpu_irq_req,
    .cpu_nmi_req, .vector_fetch, .watchdog_fail, .clock_monitor_fail,
    .reset_pin_in, .reset_pin_out, .reset_pin_oe, .core_reset,
    .stop_exit_req, .stop_exit_done);

  ext_side_model partner (
    .ref_clk, .reset_pin_out, .reset_pin_oe, .reset_pin_in,
    .ext_request_pin_n, .nonmaskable_request_pin_n);

  // 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // Verdict and end of run
  task automatic stop_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // Compare and report
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  // One-cycle register write
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr

  // Register read, data taken in the cycle after the strobe
  task automatic rd(input logic [1:0] a);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask : rd

  // Service sequence after pins settle through the synchronisers
  task automatic svc(input logic [15:0] exp);
    repeat (3) @(posedge ref_clk);
    service_start <= 1'b1;
    @(posedge ref_clk);
    service_start <= 1'b0;
    #1 check({15'h0, vector_fetch.valid}, 16'h1);
    check(vector_fetch.addr, exp);
  endtask : svc

  // Follow a reset sequence up to its vector pulse
  task automatic rst_wait(input logic [15:0] exp, input logic [1:0] cause,
                          input int tot);
    int n;
    int oe;
    n = 1;
    oe = 0;
    #1;
    while (vector_fetch.valid !== 1'b1 && n < 300) begin
      oe += int'(reset_pin_oe);
      @(posedge ref_clk);
      #1 n++;
    end
    if (tot > 0) begin
      check(16'(n), 16'(tot));
      check(16'(oe), 16'd16);
    end
    check(vector_fetch.addr, exp);
    check({14'h0, vector_fetch.reset, core_reset}, 16'h2);
    rd(STATUS_OFS);
    check({14'h0, d[7:6]}, {14'h0, cause});
  endtask : rst_wait

  // Stop exit, cycles from request to done
  task automatic stop_chk(input int exp);
    int n;
    @(posedge ref_clk);
    stop_exit_req <= 1'b1;
    @(posedge ref_clk);
    stop_exit_req <= 1'b0;
    n = 1;
    #1;
    while (stop_exit_done !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check(16'(n), 16'(exp));
  endtask : stop_chk

  // Main sequence
  initial begin
    {reset, ccr_i_mask, ccr_x_mask} = 3'b111;
    {wr_en, rd_en, special_mode, service_start, stop_exit_req} = 5'h0;
    {unimpl_trap_req, software_trap_req} = 2'b00;
    {watchdog_fail, clock_monitor_fail} = 2'b00;
    {addr, wr_data, periph_req, periph_enable} = 50'h0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    rst_wait(VEC_RESET, CAUSE_POR, 0);
    rd(PRIO_SEL_OFS);
    check({8'h0, d}, 16'h00f2);
    rd(EXT_CTRL_OFS);
    check({13'h0, d[7:5]}, 16'h3);
    rd(2'h3);
    check({8'h0, d}, 16'h0);
    stop_chk(SD + 1);
    ccr_i_mask <= 1'b0;
    wr(PRIO_SEL_OFS, 8'he4);
    rd(PRIO_SEL_OFS);
    check({8'h0, d}, 16'h00f2);
    periph_enable <= 20'hfffff;
    svc(16'hfff8);
    periph_req <= 20'h00029;
    svc(16'hfff0);
    check({15'h0, cpu_irq_req}, 16'h1);
    periph_enable <= 20'hffffe;
    svc(16'hffea);
    periph_enable <= 20'hfffff;
    ccr_i_mask <= 1'b1;
    wr(PRIO_SEL_OFS, 8'he4);
    #1 check({15'h0, cpu_irq_req}, 16'h0);
    rd(PRIO_SEL_OFS);
    check({8'h0, d}, 16'h00e4);
    ccr_i_mask <= 1'b0;
    periph_req <= 20'h00049;
    svc(16'hffe4);
    periph_req <= 20'h00009;
    svc(16'hfff0);
    periph_req <= 20'h00049;
    partner.set_pins(1'b0, 1'b1);
    svc(16'hffe4);
    ccr_i_mask <= 1'b1;
    wr(PRIO_SEL_OFS, 8'hf8);
    ccr_i_mask <= 1'b0;
    svc(16'hfff2);
    svc(16'hfff2);
    partner.set_pins(1'b0, 1'b0);
    ccr_x_mask <= 1'b0;
    svc(16'hfff4);
    check({15'h0, cpu_nmi_req}, 16'h1);
    software_trap_req <= 1'b1;
    svc(16'hfff6);
    unimpl_trap_req <= 1'b1;
    svc(16'hfff8);
    {unimpl_trap_req, software_trap_req, ccr_x_mask} <= 3'b001;
    svc(16'hfff2);
    check({15'h0, cpu_nmi_req}, 16'h0);
    periph_req <= 20'h0;
    wr(EXT_CTRL_OFS, 8'h00);
    svc(16'hfff8);
    wr(EXT_CTRL_OFS, 8'he0);
    rd(EXT_CTRL_OFS);
    check({13'h0, d[7:5]}, 16'h2);
    svc(16'hfff2);
    stop_chk(1);
    partner.set_pins(1'b1, 1'b1);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      watchdog_fail <= (k == 0);
      clock_monitor_fail <= (k == 1);
      #1 check({15'h0, core_reset}, 16'h1);
      @(posedge ref_clk);
      watchdog_fail <= 1'b0;
      clock_monitor_fail <= 1'b0;
      rst_wait(k ? VEC_CMON : VEC_WDOG, k ? CAUSE_CMON : CAUSE_WDOG, 25);
    end
    partner.pull_reset(40);
    rst_wait(VEC_RESET, CAUSE_EXT, 0);
    @(posedge ref_clk);
    special_mode <= 1'b1;
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rst_wait(VEC_RESET, CAUSE_POR, 0);
    wr(EXT_CTRL_OFS, 8'h80);
    rd(EXT_CTRL_OFS);
    check({13'h0, d[7:5]}, 16'h0);
    wr(EXT_CTRL_OFS, 8'hc0);
    rd(EXT_CTRL_OFS);
    check({13'h0, d[7:5]}, 16'h6);
    partner.set_pins(1'b0, 1'b1);
    repeat (2) @(posedge ref_clk);
    partner.set_pins(1'b1, 1'b1);
    svc(16'hfff2);
    svc(16'hfff8);
    wr(EXT_CTRL_OFS, 8'h60);
    rd(EXT_CTRL_OFS);
    check({13'h0, d[7:5]}, 16'h3);
    stop_chk(SD + 1);
    stop_test();
  end
endmodule : tb
`default_nettype wire
